// ==== core/sdram_mux_pkg.sv ====
// Constants and carrier types for the SDRAM address multiplexer
package sdram_mux_pkg;

  localparam int ADDR_W         = 28;
  localparam int MA_W           = 13;
  localparam int BANK_W         = 2;
  localparam int BANK_LO        = 15;
  localparam int BANK_HI        = 16;
  localparam int MA_LO          = 2;
  localparam int MA_HI          = 14;
  localparam int MA_PRECHG      = 10;
  localparam int SIZE_LOG_BASE  = 22;
  localparam int LARGE_CHIP_LOG = 25;
  localparam int ROW_BITS_SMALL = 12;
  localparam int ROW_BITS_LARGE = 13;
  localparam int BEATS_MULTI    = 4;

  localparam logic [2:0] DSZ_8MB  = 3'h1;
  localparam logic [2:0] DSZ_16MB = 3'h2;
  localparam logic [2:0] DSZ_32MB = 3'h3;
  localparam logic [2:0] DSZ_64MB = 3'h4;
  localparam logic [1:0] DBW_8    = 2'h0;
  localparam logic [1:0] DBW_16   = 2'h1;
  localparam logic [1:0] BUS_8    = 2'h2;
  localparam logic [1:0] BUS_16   = 2'h0;
  localparam logic [2:0] CL_2     = 3'h2;
  localparam logic [2:0] CL_3     = 3'h3;

  // Per-channel timing and geometry fields
  typedef struct packed {
    logic [2:0] row_active_time_field;
    logic [1:0] row_to_col_delay_field;
    logic [2:0] precharge_time_field;
    logic [2:0] cas_latency_field;
    logic       write_recovery_field;
    logic [1:0] sdram_data_width_field;
    logic [2:0] sdram_size_field;
    logic [1:0] ext_bus_width_field;
  } chan_cfg_t;

  typedef struct packed {
    logic              sdram;
    logic              write;
    logic              multi;
    logic              auto_pre;
    logic [ADDR_W-1:0] addr;
  } access_req_t;

  typedef enum logic [2:0] {
    CMD_NOP, CMD_ACT, CMD_READ, CMD_WRITE, CMD_PRE, CMD_DPD_ENTER, CMD_DPD_EXIT
  } sdram_cmd_t;

endpackage

// ==== core/sdram_addr_mux.sv ====
// SDRAM address multiplexer with access sequencing and deep-power-down
//
// Functional notes
// - Read timing from row, rcd, precharge, CAS
// - Write timing swaps CAS for one-bit write recovery
// - Pins carry external or SDRAM address
// - Address shift by width, size, bus
// - Bank address on lines 16 and 15
// - Row or column address on lines 14..2
// - Lines 14..2 shared; MA12 line 14
// - Request 1 enters, 0 exits, raises CKE
// - Size codes 001..100 select 8..64 Mbytes
// - Data width and bus width encodings
`timescale 1ns/10ps
module sdram_addr_mux #(
  parameter int CHANNELS = 2,
  parameter int CH_W     = 1,
  parameter int BEATS    = sdram_mux_pkg::BEATS_MULTI
) (
  input  wire logic                                   clk,
  input  wire logic                                   rst,
  input  wire sdram_mux_pkg::chan_cfg_t [CHANNELS-1:0] chan_cfg,
  input  wire logic                                   req_valid,
  input  wire sdram_mux_pkg::access_req_t             req,
  input  wire logic [CH_W-1:0]                        req_ch,
  input  wire logic                                   deep_power_down_request,
  output logic                                        req_ready,
  output logic [sdram_mux_pkg::ADDR_W-1:0]            ext_addr,
  output logic                                        sdram_sel,
  output sdram_mux_pkg::sdram_cmd_t                   sdram_cmd,
  output logic                                        sdram_clock_enable_out,
  output logic                                        in_deep_power_down,
  output logic                                        access_done
);

  typedef enum {ST_IDLE, ST_ACT, ST_COL, ST_TAIL, ST_PRE, ST_DPD} state_t;
  typedef logic [sdram_mux_pkg::ADDR_W-1:0] addr_t;

  ////////////////////////////////////////////////////////////////////////////
  // Address geometry

  function automatic int size_log(sdram_mux_pkg::chan_cfg_t c);
    logic [2:0] s;
    s = c.sdram_size_field;
    // Undefined size codes fall back to the smallest part
    if (s < sdram_mux_pkg::DSZ_8MB || s > sdram_mux_pkg::DSZ_64MB)
      s = sdram_mux_pkg::DSZ_8MB;
    return sdram_mux_pkg::SIZE_LOG_BASE + int'(s);
  endfunction

  function automatic int row_bits(sdram_mux_pkg::chan_cfg_t c);
    int chip;
    chip = size_log(c);
    // Two byte-wide parts side by side halve the size of each part
    if (c.ext_bus_width_field == sdram_mux_pkg::BUS_16 &&
        c.sdram_data_width_field == sdram_mux_pkg::DBW_8)
      chip = chip - 1;
    return (chip >= sdram_mux_pkg::LARGE_CHIP_LOG) ?
           sdram_mux_pkg::ROW_BITS_LARGE : sdram_mux_pkg::ROW_BITS_SMALL;
  endfunction

  function automatic int row_base(sdram_mux_pkg::chan_cfg_t c);
    return size_log(c) - sdram_mux_pkg::BANK_W - row_bits(c);
  endfunction

  function automatic int col_base(sdram_mux_pkg::chan_cfg_t c);
    return (c.ext_bus_width_field == sdram_mux_pkg::BUS_16) ? 1 : 0;
  endfunction

  function automatic addr_t bank_pins(addr_t a, sdram_mux_pkg::chan_cfg_t c);
    addr_t sh;
    addr_t p;
    sh = a >> (size_log(c) - sdram_mux_pkg::BANK_W);
    p = '0;
    p[sdram_mux_pkg::BANK_HI:sdram_mux_pkg::BANK_LO] = sh[1:0];
    return p;
  endfunction

  function automatic addr_t row_pins(addr_t a, sdram_mux_pkg::chan_cfg_t c);
    addr_t sh;
    addr_t p;
    sh = (a >> row_base(c)) & ((28'h0000001 << row_bits(c)) - 28'h0000001);
    p = bank_pins(a, c);
    p[sdram_mux_pkg::MA_HI:sdram_mux_pkg::MA_LO] = sh[12:0];
    return p;
  endfunction

  function automatic addr_t col_pins(addr_t a, sdram_mux_pkg::chan_cfg_t c,
                                     logic ap);
    addr_t sh;
    addr_t p;
    logic [sdram_mux_pkg::MA_W-1:0] ma;
    sh = (a >> col_base(c)) &
         ((28'h0000001 << (row_base(c) - col_base(c))) - 28'h0000001);
    // MA10 carries the precharge option, so column bit 10 skips to MA11
    ma = {sh[11:10], ap, sh[9:0]};
    p = bank_pins(a, c);
    p[sdram_mux_pkg::MA_HI:sdram_mux_pkg::MA_LO] = ma;
    return p;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  state_t                     state_r, state_nxt;
  logic [3:0]                 cnt_r, cnt_nxt;
  logic [4:0]                 el_r, el_nxt;
  logic [3:0]                 tail_r, tail_nxt;
  sdram_mux_pkg::chan_cfg_t   cfg_r, cfg_nxt;
  sdram_mux_pkg::access_req_t req_r, req_nxt;
  addr_t                      addr_r, addr_nxt;
  sdram_mux_pkg::sdram_cmd_t  cmd_r, cmd_nxt;
  logic                       cke_r, cke_nxt;
  logic                       sel_r, sel_nxt;
  logic                       done_r, done_nxt;

  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    el_nxt    = (el_r == 5'h1F) ? el_r : el_r + 5'h01;
    tail_nxt  = tail_r;
    cfg_nxt   = cfg_r;
    req_nxt   = req_r;
    addr_nxt  = addr_r;
    cmd_nxt   = sdram_mux_pkg::CMD_NOP;
    cke_nxt   = cke_r;
    sel_nxt   = sel_r;
    done_nxt  = 1'b0;
    unique case (state_r)
      ST_IDLE:
      begin
        // Entry only from idle, so no access is cut short
        if (deep_power_down_request)
        begin
          state_nxt = ST_DPD;
          cmd_nxt   = sdram_mux_pkg::CMD_DPD_ENTER;
          cke_nxt   = 1'b0;
        end
        else if (req_valid)
        begin
          req_nxt = req;
          cfg_nxt = chan_cfg[req_ch];
          if (req.sdram)
          begin
            state_nxt = ST_ACT;
            cmd_nxt   = sdram_mux_pkg::CMD_ACT;
            sel_nxt   = 1'b1;
            addr_nxt  = row_pins(req.addr, chan_cfg[req_ch]);
            cnt_nxt   = {2'h0, chan_cfg[req_ch].row_to_col_delay_field};
            el_nxt    = 5'h00;
          end
          else
          begin
            sel_nxt  = 1'b0;
            addr_nxt = req.addr;
            done_nxt = 1'b1;
          end
        end
      end
      ST_ACT:
      begin
        if (cnt_r == 4'h0)
        begin
          state_nxt = ST_COL;
          cmd_nxt   = req_r.write ? sdram_mux_pkg::CMD_WRITE :
                                    sdram_mux_pkg::CMD_READ;
          addr_nxt  = col_pins(req_r.addr, cfg_r, req_r.auto_pre);
          cnt_nxt   = req_r.multi ? 4'(BEATS - 1) : 4'h0;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      ST_COL:
      begin
        if (cnt_r == 4'h0)
        begin
          state_nxt = ST_TAIL;
          tail_nxt  = 4'h0;
          cnt_nxt   = req_r.write ?
                      {3'h0, cfg_r.write_recovery_field} + 4'h1 :
                      {1'h0, cfg_r.cas_latency_field};
        end
        else
        begin
          cmd_nxt = cmd_r;
          cnt_nxt = cnt_r - 4'h1;
        end
      end
      ST_TAIL:
      begin
        tail_nxt = tail_r + 4'h1;
        // Hold the row open for its minimum active time as well
        if (cnt_r == 4'h0 && el_r > {2'h0, cfg_r.row_active_time_field})
        begin
          state_nxt = ST_PRE;
          cmd_nxt   = sdram_mux_pkg::CMD_PRE;
          cnt_nxt   = {1'h0, cfg_r.precharge_time_field};
        end
        else if (cnt_r != 4'h0)
          cnt_nxt = cnt_r - 4'h1;
      end
      ST_PRE:
      begin
        if (cnt_r == 4'h0)
        begin
          state_nxt = ST_IDLE;
          done_nxt  = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 4'h1;
      end
      ST_DPD:
      begin
        // Software must still run an init sequence after this exit
        if (!deep_power_down_request)
        begin
          state_nxt = ST_IDLE;
          cmd_nxt   = sdram_mux_pkg::CMD_DPD_EXIT;
          cke_nxt   = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= ST_IDLE;
      cnt_r   <= 4'h0;
      el_r    <= 5'h00;
      tail_r  <= 4'h0;
      cfg_r   <= '0;
      req_r   <= '0;
      addr_r  <= '0;
      cmd_r   <= sdram_mux_pkg::CMD_NOP;
      cke_r   <= 1'b1;
      sel_r   <= 1'b0;
      done_r  <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      el_r    <= el_nxt;
      tail_r  <= tail_nxt;
      cfg_r   <= cfg_nxt;
      req_r   <= req_nxt;
      addr_r  <= addr_nxt;
      cmd_r   <= cmd_nxt;
      cke_r   <= cke_nxt;
      sel_r   <= sel_nxt;
      done_r  <= done_nxt;
    end
  end

  // Masters are held off while busy or powered down
  assign req_ready              = state_r == ST_IDLE &&
                                  !deep_power_down_request;
  assign ext_addr               = addr_r;
  assign sdram_sel              = sel_r;
  assign sdram_cmd              = cmd_r;
  assign sdram_clock_enable_out = cke_r;
  assign in_deep_power_down     = state_r == ST_DPD;
  assign access_done            = done_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_ext_pass;
    req_valid && req_ready && !req.sdram |=>
      ext_addr == $past(req.addr) && access_done && !sdram_sel;
  endproperty
  a_ext_pass: assert property (p_ext_pass)
    else $error("external address not passed through");

  property p_sdram_only_pins;
    sdram_sel |-> ext_addr[27:17] == 11'h000 && ext_addr[1:0] == 2'h0;
  endproperty
  a_sdram_only_pins: assert property (p_sdram_only_pins)
    else $error("SDRAM access drives an external-only line");

  property p_bank_8bit;
    sdram_cmd == sdram_mux_pkg::CMD_ACT &&
    cfg_r.ext_bus_width_field == sdram_mux_pkg::BUS_8 &&
    cfg_r.sdram_size_field == sdram_mux_pkg::DSZ_8MB |->
      ext_addr[16:15] == req_r.addr[22:21] &&
      ext_addr[14:2] == {1'b0, req_r.addr[20:9]};
  endproperty
  a_bank_8bit: assert property (p_bank_8bit)
    else $error("bank or row misplaced for 8 Mbyte part");

  property p_col_64mb;
    sdram_cmd == sdram_mux_pkg::CMD_READ &&
    cfg_r.ext_bus_width_field == sdram_mux_pkg::BUS_8 &&
    cfg_r.sdram_size_field == sdram_mux_pkg::DSZ_64MB |->
      ext_addr[13] == req_r.addr[10] && ext_addr[14] == 1'b0 &&
      ext_addr[11:2] == req_r.addr[9:0];
  endproperty
  a_col_64mb: assert property (p_col_64mb)
    else $error("column bit 10 not on line 13");

  property p_shift_16bit;
    sdram_cmd inside {sdram_mux_pkg::CMD_ACT, sdram_mux_pkg::CMD_READ} &&
    cfg_r.ext_bus_width_field == sdram_mux_pkg::BUS_16 &&
    cfg_r.sdram_data_width_field == sdram_mux_pkg::DBW_16 &&
    cfg_r.sdram_size_field == sdram_mux_pkg::DSZ_16MB |->
      (sdram_cmd == sdram_mux_pkg::CMD_ACT) ?
        ext_addr[14:2] == {1'b0, req_r.addr[21:10]} :
        ext_addr[10:2] == req_r.addr[9:1];
  endproperty
  a_shift_16bit: assert property (p_shift_16bit)
    else $error("16-bit bus shift wrong");

  // First column command of an access: the row timer tells the gap
  property p_rcd;
    sdram_cmd inside {sdram_mux_pkg::CMD_READ, sdram_mux_pkg::CMD_WRITE} &&
    $past(state_r) == ST_ACT |->
      el_r == {3'h0, cfg_r.row_to_col_delay_field} + 5'h01;
  endproperty
  a_rcd: assert property (p_rcd)
    else $error("row-to-column delay not honoured");

  property p_cas_tail;
    state_r == ST_TAIL && state_nxt == ST_PRE && !req_r.write |->
      tail_r >= {1'h0, cfg_r.cas_latency_field} &&
      el_r > {2'h0, cfg_r.row_active_time_field};
  endproperty
  a_cas_tail: assert property (p_cas_tail)
    else $error("read closed before CAS latency");

  property p_wr_tail;
    state_r == ST_TAIL && state_nxt == ST_PRE && req_r.write |->
      tail_r >= {3'h0, cfg_r.write_recovery_field} + 4'h1;
  endproperty
  a_wr_tail: assert property (p_wr_tail)
    else $error("write recovery too short");

  property p_cfg_latch;
    req_valid && req_ready |=> cfg_r == $past(chan_cfg[req_ch]);
  endproperty
  a_cfg_latch: assert property (p_cfg_latch)
    else $error("channel fields not taken from chosen channel");

  property p_dpd;
    state_r == ST_IDLE && deep_power_down_request |=>
      sdram_cmd == sdram_mux_pkg::CMD_DPD_ENTER && !sdram_clock_enable_out &&
      in_deep_power_down
      ##1 ((in_deep_power_down && !sdram_clock_enable_out) ||
           (sdram_cmd == sdram_mux_pkg::CMD_DPD_EXIT &&
            sdram_clock_enable_out));
  endproperty
  a_dpd: assert property (p_dpd)
    else $error("deep-power-down entry wrong");

  property p_dpd_exit;
    in_deep_power_down && !deep_power_down_request |=>
      sdram_cmd == sdram_mux_pkg::CMD_DPD_EXIT && sdram_clock_enable_out &&
      !in_deep_power_down;
  endproperty
  a_dpd_exit: assert property (p_dpd_exit)
    else $error("deep-power-down exit wrong");

  c_read: cover property (sdram_cmd == sdram_mux_pkg::CMD_READ ##[1:40]
                          access_done);
  c_write_multi: cover property ((req_r.multi &&
                                  sdram_cmd == sdram_mux_pkg::CMD_WRITE)[*4]);
  c_dpd_cycle: cover property (sdram_cmd == sdram_mux_pkg::CMD_DPD_ENTER
                               ##[1:20] sdram_cmd == sdram_mux_pkg::CMD_DPD_EXIT);

endmodule

// ==== test/sdram_dev_model.sv ====
// Behavioural SDRAM device seen through the shared address pins
`timescale 1ns/10ps
module sdram_dev_model (
  input  wire logic                             clk,
  input  wire logic                             rst,
  input  wire logic [sdram_mux_pkg::ADDR_W-1:0] ext_addr,
  input  wire sdram_mux_pkg::sdram_cmd_t        sdram_cmd,
  input  wire logic                             cke,
  output logic [sdram_mux_pkg::ADDR_W-1:0]      act_addr,
  output logic [sdram_mux_pkg::ADDR_W-1:0]      col_addr,
  output logic [3:0]                            beats,
  output logic                                  bad_cmd
);
  //////////////////////////////////////////////////////////////////////////
  // Latch the pins per command so the bench can inspect each phase
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      act_addr <= '0;
      col_addr <= '0;
      beats    <= 4'h0;
      bad_cmd  <= 1'b0;
    end
    else
    begin
      if (sdram_cmd == sdram_mux_pkg::CMD_ACT)
      begin
        act_addr <= ext_addr;
        beats    <= 4'h0;
      end
      if (sdram_cmd == sdram_mux_pkg::CMD_READ ||
          sdram_cmd == sdram_mux_pkg::CMD_WRITE)
      begin
        col_addr <= ext_addr;
        beats    <= beats + 4'h1;
      end
      // A sleeping part accepts only NOP and the deep-power-down entry and exit commands
      if (!cke && sdram_cmd != sdram_mux_pkg::CMD_NOP &&
          sdram_cmd != sdram_mux_pkg::CMD_DPD_EXIT &&
          sdram_cmd != sdram_mux_pkg::CMD_DPD_ENTER)
        bad_cmd <= 1'b1;
    end
  end
endmodule

// ==== test/sdram_addr_mux_test.sv ====
// Directed bench for the SDRAM address multiplexer
`timescale 1ns/10ps
module sdram_addr_mux_test;
  localparam int             AW = sdram_mux_pkg::ADDR_W;
  localparam logic [AW-1:0]  A1 = 28'hB6D3C0B;
  localparam logic [AW-1:0]  A2 = 28'h3C9A804;
  logic                           clk;
  logic                           rst;
  sdram_mux_pkg::chan_cfg_t [1:0] cfg;
  logic                           req_valid;
  sdram_mux_pkg::access_req_t     req;
  logic [0:0]                     req_ch;
  logic                           deep_power_down_request;
  logic                           req_ready;
  logic [AW-1:0]                  ext_addr;
  logic                           sdram_sel;
  sdram_mux_pkg::sdram_cmd_t      sdram_cmd;
  logic                           cke;
  logic                           in_dpd;
  logic                           access_done;
  logic [AW-1:0]                  act_addr;
  logic [AW-1:0]                  col_addr;
  logic [3:0]                     beats;
  logic                           bad_cmd;
  int                             error_cnt;
  int                             check_count;
  int                             cyc;
  int                             l0;
  int                             l1;
  logic [14:0]                    re;

  sdram_addr_mux i_sdram_addr_mux (.clk(clk), .rst(rst), .chan_cfg(cfg),
    .req_valid(req_valid), .req(req), .req_ch(req_ch),
    .deep_power_down_request(deep_power_down_request),
    .req_ready(req_ready), .ext_addr(ext_addr), .sdram_sel(sdram_sel),
    .sdram_cmd(sdram_cmd), .sdram_clock_enable_out(cke),
    .in_deep_power_down(in_dpd), .access_done(access_done));

  sdram_dev_model i_sdram_dev_model (.clk(clk), .rst(rst),
    .ext_addr(ext_addr), .sdram_cmd(sdram_cmd), .cke(cke),
    .act_addr(act_addr), .col_addr(col_addr), .beats(beats),
    .bad_cmd(bad_cmd));

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Longest run is a few hundred cycles; the ceiling leaves wide margin
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      error_cnt++;
      summarize();
    end
  end

  //////////////////////////////////////////////////////////////////////////
  task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bank and row as they should appear on lines 16..2 for a size code
  function automatic logic [14:0] row_exp(logic [AW-1:0] a, int sz);
    logic [AW-1:0] t;
    int            rb;
    rb = (sz >= 3) ? 13 : 12;
    t  = a >> (20 + sz - rb);
    return {a[20+sz+:2], t[12:0] & 13'((1 << rb) - 1)};
  endfunction

  // Request is held until the edge that finds ready high
  task automatic access(logic ch, logic sd, logic wr, logic mu,
                        logic [AW-1:0] a, output int lat);
    @(posedge clk);
    req_valid <= 1'b1;
    req_ch    <= ch;
    req       <= '{sdram: sd, write: wr, multi: mu, auto_pre: a[1], addr: a};
    do @(negedge clk); while (req_ready !== 1'b1);
    @(posedge clk);
    req_valid <= 1'b0;
    lat = 0;
    do
    begin
      @(negedge clk);
      lat++;
    end
    while (access_done !== 1'b1 && lat < 200);
  endtask

  task automatic timed(logic [2:0] ras, logic [1:0] rcd, logic [2:0] pcg,
                       logic [2:0] cl, logic wrf, logic wr, logic mu,
                       output int lat);
    @(posedge clk);
    cfg[0].row_active_time_field  <= ras;
    cfg[0].row_to_col_delay_field <= rcd;
    cfg[0].precharge_time_field   <= pcg;
    cfg[0].cas_latency_field      <= cl;
    cfg[0].write_recovery_field   <= wrf;
    access(1'b0, 1'b1, wr, mu, A1, lat);
    check("beats", beats, mu ? 4 : 1);
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst = 1'b1;
    req_valid = 1'b0;
    req = '0;
    req_ch = 1'b0;
    deep_power_down_request = 1'b0;
    cfg[0] = '{3'h0, 2'h0, 3'h0, sdram_mux_pkg::CL_2, 1'b0,
               sdram_mux_pkg::DBW_8, sdram_mux_pkg::DSZ_8MB,
               sdram_mux_pkg::BUS_8};
    cfg[1] = '{3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_3, 1'b0,
               sdram_mux_pkg::DBW_16, sdram_mux_pkg::DSZ_16MB,
               sdram_mux_pkg::BUS_16};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    check("rst addr", ext_addr, 0);
    check("rst cke", {cke, in_dpd, sdram_sel, req_ready}, 4'h9);
    access(1'b0, 1'b0, 1'b0, 1'b0, 28'hABCDEF3, l0);
    check("ext lat", l0, 1);
    check("ext addr", {sdram_sel, ext_addr},
          {1'b0, 28'hABCDEF3});
    for (int s = 1; s <= 4; s++)
    begin
      @(posedge clk);
      cfg[0].sdram_size_field <= 3'(s);
      access(1'b0, 1'b1, 1'b0, 1'b0, A1, l0);
      re = row_exp(A1, s);
      check("sel", sdram_sel, 1);
      check("row", act_addr[16:2], re);
      check("col", {col_addr[16:15], col_addr[12], col_addr[5:2]},
            {re[14:13], A1[1], A1[3:0]});
    end
    @(posedge clk);
    cfg[0].sdram_size_field <= sdram_mux_pkg::DSZ_8MB;
    timed(3'h0, 2'h0, 3'h0, sdram_mux_pkg::CL_2, 1'b0, 1'b0, 1'b0, l0);
    check("lat walk", l0, 7);
    // Active time longer than the tail keeps the row open past it
    timed(3'h6, 2'h0, 3'h1, sdram_mux_pkg::CL_2, 1'b0, 1'b0, 1'b0, l0);
    check("lat ras", l0, 11);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_2, 1'b0, 1'b0, 1'b0, l0);
    check("lat rcd", l0, 9);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_3, 1'b0, 1'b0, 1'b0, l1);
    check("lat cl", l1, l0 + 1);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_3, 1'b0, 1'b0, 1'b1, l1);
    check("lat multi", l1, l0 + 4);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_2, 1'b0, 1'b1, 1'b0, l0);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_2, 1'b1, 1'b1, 1'b0, l1);
    check("lat wr", l1, l0 + 1);
    timed(3'h0, 2'h1, 3'h1, sdram_mux_pkg::CL_2, 1'b1, 1'b1, 1'b1, l0);
    check("lat mwr", l0, l1 + 3);
    // Second channel: wider bus, larger part, slower CAS
    access(1'b1, 1'b1, 1'b0, 1'b0, A2, l1);
    check("ch lat", l1, 10);
    re = row_exp(A2, 2);
    check("ch row", act_addr[16:2], re);
    check("ch col", {col_addr[16:15], col_addr[12], col_addr[4:2]},
          {re[14:13], A2[1], A2[3:1]});
    // All traffic is idle here before the sleep request
    @(posedge clk);
    deep_power_down_request <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("dpd in", {sdram_cmd, cke, in_dpd},
          {sdram_mux_pkg::CMD_DPD_ENTER, 2'b01});
    @(posedge clk);
    req_valid <= 1'b1;
    req <= '{1'b1, 1'b0, 1'b0, 1'b0, A1};
    repeat (10)
    begin
      @(negedge clk);
      check("dpd ready", {req_ready, cke}, 2'b00);
    end
    @(posedge clk);
    req_valid <= 1'b0;
    deep_power_down_request <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    check("dpd out", {sdram_cmd, cke, in_dpd},
          {sdram_mux_pkg::CMD_DPD_EXIT, 2'b10});
    // Settling time before the part is used again
    repeat (20) @(posedge clk);
    access(1'b0, 1'b1, 1'b0, 1'b0, A1, l0);
    check("wake", {l0 < 200, bad_cmd}, 2'b10);
    summarize();
  end
endmodule
